// ---- pkg/cgor_pkg.sv ----
// constants for the clock generator output configuration register bank
package cgor_pkg;

    // register byte offsets
    localparam logic [7:0] OUTPUT_CONTROL_OFS   = 8'h03;
    localparam logic [7:0] PROC_MULT_HIGH_OFS   = 8'h04;
    localparam logic [7:0] PROC_MULT_LOW_OFS    = 8'h05;
    localparam logic [7:0] RESERVED_A_OFS       = 8'h06;
    localparam logic [7:0] RESERVED_B_OFS       = 8'h07;
    localparam logic [7:0] RESERVED_C_OFS       = 8'h08;
    localparam logic [7:0] PANEL_MULT_OFS       = 8'h09;
    localparam logic [7:0] STATUS_READBACK_OFS  = 8'h0a;

    // output control field positions
    localparam int REF_ENABLE_BIT     = 5;
    localparam int REF_EDGE_RATE_HI   = 4;
    localparam int REF_EDGE_RATE_LO   = 3;
    localparam int HALT_SELECT0_BIT   = 2;
    localparam int HALT_SELECT1_BIT   = 1;
    localparam int HALT_SELECT2_BIT   = 0;

    // multiplier msb position in the high byte and panel msb in byte 8
    localparam int PROC_MULT_MSB_BIT  = 0;
    localparam int PANEL_MSB_BIT      = 7;

    // status field positions
    localparam int FS_B_BIT           = 7;
    localparam int FS_C_BIT           = 6;
    localparam int CLK_REQ0_BIT       = 5;
    localparam int CLK_REQ1_BIT       = 4;
    localparam int CLK_REQ2_BIT       = 3;

    // edge rate encodings
    localparam logic [1:0] EDGE_RATE_MEDIUM   = 2'h1;
    localparam logic [1:0] EDGE_RATE_FAST     = 2'h2;
    localparam logic [1:0] EDGE_RATE_RESERVED = 2'h3;

    // reset values
    localparam logic       REF_ENABLE_RST     = 1'h1;
    localparam logic [1:0] REF_EDGE_RATE_RST  = EDGE_RATE_FAST;
    localparam logic [2:0] HALT_SELECT_RST    = 3'h0;
    localparam logic       PROC_MULT_MSB_RST  = 1'h0;
    localparam logic [7:0] OUTPUT_CTRL_RSVD   = 8'h00;
    localparam logic [7:0] PROC_MULT_HI_RSVD  = 8'hfe;
    localparam logic [7:0] RESERVED_A_VALUE   = 8'hc3;
    localparam logic [7:0] RESERVED_B_VALUE   = 8'h00;
    localparam logic [7:0] RESERVED_C_VALUE   = 8'h00;
    localparam logic [7:0] STATUS_RSVD        = 8'h00;
    localparam logic [7:0] UNMAPPED_VALUE     = 8'h00;

    // multiplier low byte defaults, indexed by {fs_c, fs_b}
    localparam logic [7:0] PROC_MULT_LOW_FS0  = 8'h10;
    localparam logic [7:0] PROC_MULT_LOW_FS1  = 8'h20;
    localparam logic [7:0] PROC_MULT_LOW_FS2  = 8'h30;
    localparam logic [7:0] PROC_MULT_LOW_FS3  = 8'h40;
    // panel multiplier low byte, fixed
    localparam logic [7:0] PANEL_MULT_VALUE   = 8'h64;

    // cycles spent settling after reset release, before the one strap latch cycle
    localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h2;

    // strap latch sequencing
    typedef enum logic [1:0] {
        CGOR_SETTLE,
        CGOR_LATCH,
        CGOR_RUN
    } cgor_state_t;

endpackage

// ---- hdl/cgor_sync.sv ----
// two flip-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
module cgor_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_reset,
    // asynchronous levels in, synchronised levels out
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // first stage feeds only the second
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;

endmodule

// ---- hdl/cgor_regs.sv ----
// output configuration and status register bank of the clock generator
//
// Notes on behaviour
// - reference output buffer enable at bit 5 of output control, default on.
// - reference edge rate bits 4:3: 01 medium, 10 fast default, 11 reserved.
// - bits 2,1,0 pick free running or stoppable; stoppable stops on halt.
// - multiplier msb is bit 0 of byte 4, default 0, rest reserved.
// - multiplier low byte in byte 5, default from latched frequency select.
// - panel multiplier is byte 9 with byte 8 bit 7; byte 9 read-only.
// - status bits 7 and 6 show select inputs B and C latched at start.
// - status bits 5,4,3 show live clock request levels, not latched.
`timescale 1ns/1ps
module cgor_regs (
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_reset,
    // byte register port from the management bus engine
    input  wire logic       i_wr_en,
    input  wire logic       i_rd_en,
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wdata,
    output logic      [7:0] o_rdata,
    output logic            o_rdata_valid,
    output logic            o_ready,
    // pins
    input  wire logic       i_freq_select_b,
    input  wire logic       i_freq_select_c,
    input  wire logic [2:0] i_clock_request_n,
    input  wire logic       i_processor_clock_halt_n,
    // controls to the clock outputs
    output logic            o_ref_enable,
    output logic      [1:0] o_ref_edge_rate,
    output logic      [2:0] o_processor_clock_enable,
    output logic      [8:0] o_processor_pll_multiplier,
    output logic      [8:0] o_panel_pll_multiplier
);

    // multiplier default chosen by the latched selects
    function automatic logic [7:0] mult_default(input logic [1:0] fs);
        case (fs)
            2'h0:    mult_default = cgor_pkg::PROC_MULT_LOW_FS0;
            2'h1:    mult_default = cgor_pkg::PROC_MULT_LOW_FS1;
            2'h2:    mult_default = cgor_pkg::PROC_MULT_LOW_FS2;
            default: mult_default = cgor_pkg::PROC_MULT_LOW_FS3;
        endcase
    endfunction

    // synchronised pins: {fs_c, fs_b, request[2:0], halt_n}
    logic [5:0]             pins_sync;
    logic                   fs_b_sync;
    logic                   fs_c_sync;
    logic [2:0]             req_sync;
    logic                   halt_n_sync;

    // strap latch
    cgor_pkg::cgor_state_t  state_q;
    logic [1:0]             settle_q;
    logic                   freq_select_b_latched;
    logic                   freq_select_c_latched;

    // register state
    logic                   ref_enable_q;
    logic [1:0]             ref_edge_rate_q;
    logic [2:0]             halt_select_q;
    logic                   processor_pll_multiplier_msb;
    logic [7:0]             processor_pll_multiplier_low_bits;
    logic [7:0]             panel_pll_multiplier_bits;
    logic [7:0]             rdata_d;
    logic                   write_ok;

    cgor_sync #(
        .WIDTH (6)
    ) u_sync (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_async ({i_freq_select_c, i_freq_select_b,
                   i_clock_request_n, i_processor_clock_halt_n}),
        .o_sync  (pins_sync)
    );

    // split synchronised pins
    assign halt_n_sync = pins_sync[0];
    assign req_sync    = pins_sync[3:1];
    assign fs_b_sync   = pins_sync[4];
    assign fs_c_sync   = pins_sync[5];

    // host writes count only once straps are latched
    assign write_ok = i_wr_en && (state_q == cgor_pkg::CGOR_RUN);

    // strap latch sequencer: wait for synchroniser, then capture once
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state_q  <= cgor_pkg::CGOR_SETTLE;
            settle_q <= 2'h0;
        end else begin
            case (state_q)
                cgor_pkg::CGOR_SETTLE: begin
                    settle_q <= settle_q + 2'h1;
                    if (settle_q == cgor_pkg::STRAP_SETTLE_CYCLES - 2'h1) begin
                        state_q <= cgor_pkg::CGOR_LATCH;
                    end
                end
                cgor_pkg::CGOR_LATCH: begin
                    state_q <= cgor_pkg::CGOR_RUN;
                end
                cgor_pkg::CGOR_RUN: begin
                    state_q <= cgor_pkg::CGOR_RUN;
                end
                default: begin
                    state_q <= cgor_pkg::CGOR_SETTLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            freq_select_b_latched <= 1'h0;
            freq_select_c_latched <= 1'h0;
        end else if (state_q == cgor_pkg::CGOR_LATCH) begin
            freq_select_b_latched <= fs_b_sync;
            freq_select_c_latched <= fs_c_sync;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            ref_enable_q    <= cgor_pkg::REF_ENABLE_RST;
            ref_edge_rate_q <= cgor_pkg::REF_EDGE_RATE_RST;
            halt_select_q   <= cgor_pkg::HALT_SELECT_RST;
        end else if (write_ok && i_addr == cgor_pkg::OUTPUT_CONTROL_OFS) begin
            ref_enable_q    <= i_wdata[cgor_pkg::REF_ENABLE_BIT];
            ref_edge_rate_q <= i_wdata[cgor_pkg::REF_EDGE_RATE_HI:
                                       cgor_pkg::REF_EDGE_RATE_LO];
            // index n of the select vector belongs to output n
            halt_select_q   <= {i_wdata[cgor_pkg::HALT_SELECT2_BIT],
                                i_wdata[cgor_pkg::HALT_SELECT1_BIT],
                                i_wdata[cgor_pkg::HALT_SELECT0_BIT]};
        end
    end

    // multiplier msb, other bits of byte 4 dropped
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            processor_pll_multiplier_msb <= cgor_pkg::PROC_MULT_MSB_RST;
        end else if (write_ok && i_addr == cgor_pkg::PROC_MULT_HIGH_OFS) begin
            processor_pll_multiplier_msb <=
                i_wdata[cgor_pkg::PROC_MULT_MSB_BIT];
        end
    end

    // multiplier low byte, default loaded at strap latch
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            processor_pll_multiplier_low_bits <= cgor_pkg::PROC_MULT_LOW_FS0;
        end else if (state_q == cgor_pkg::CGOR_LATCH) begin
            processor_pll_multiplier_low_bits <=
                mult_default({fs_c_sync, fs_b_sync});
        end else if (write_ok && i_addr == cgor_pkg::PROC_MULT_LOW_OFS) begin
            processor_pll_multiplier_low_bits <= i_wdata;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            panel_pll_multiplier_bits <= cgor_pkg::PANEL_MULT_VALUE;
        end else begin
            panel_pll_multiplier_bits <= cgor_pkg::PANEL_MULT_VALUE;
        end
    end

    // read mux
    always_comb begin
        rdata_d = cgor_pkg::UNMAPPED_VALUE;
        case (i_addr)
            cgor_pkg::OUTPUT_CONTROL_OFS: begin
                rdata_d = cgor_pkg::OUTPUT_CTRL_RSVD;
                rdata_d[cgor_pkg::REF_ENABLE_BIT] = ref_enable_q;
                rdata_d[cgor_pkg::REF_EDGE_RATE_HI:
                        cgor_pkg::REF_EDGE_RATE_LO] = ref_edge_rate_q;
                rdata_d[cgor_pkg::HALT_SELECT0_BIT] = halt_select_q[0];
                rdata_d[cgor_pkg::HALT_SELECT1_BIT] = halt_select_q[1];
                rdata_d[cgor_pkg::HALT_SELECT2_BIT] = halt_select_q[2];
            end
            cgor_pkg::PROC_MULT_HIGH_OFS: begin
                rdata_d = cgor_pkg::PROC_MULT_HI_RSVD;
                rdata_d[cgor_pkg::PROC_MULT_MSB_BIT] =
                    processor_pll_multiplier_msb;
            end
            cgor_pkg::PROC_MULT_LOW_OFS: begin
                rdata_d = processor_pll_multiplier_low_bits;
            end
            cgor_pkg::RESERVED_A_OFS: begin
                rdata_d = cgor_pkg::RESERVED_A_VALUE;
            end
            cgor_pkg::RESERVED_B_OFS: begin
                rdata_d = cgor_pkg::RESERVED_B_VALUE;
            end
            cgor_pkg::RESERVED_C_OFS: begin
                rdata_d = cgor_pkg::RESERVED_C_VALUE;
            end
            cgor_pkg::PANEL_MULT_OFS: begin
                rdata_d = panel_pll_multiplier_bits;
            end
            cgor_pkg::STATUS_READBACK_OFS: begin
                rdata_d = cgor_pkg::STATUS_RSVD;
                rdata_d[cgor_pkg::FS_B_BIT]     = freq_select_b_latched;
                rdata_d[cgor_pkg::FS_C_BIT]     = freq_select_c_latched;
                rdata_d[cgor_pkg::CLK_REQ0_BIT] = req_sync[0];
                rdata_d[cgor_pkg::CLK_REQ1_BIT] = req_sync[1];
                rdata_d[cgor_pkg::CLK_REQ2_BIT] = req_sync[2];
            end
            default: begin
                rdata_d = cgor_pkg::UNMAPPED_VALUE;
            end
        endcase
    end

    // registered read answer, one cycle after the strobe
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_rdata       <= cgor_pkg::UNMAPPED_VALUE;
            o_rdata_valid <= 1'h0;
        end else begin
            o_rdata_valid <= i_rd_en;
            if (i_rd_en) begin
                o_rdata <= rdata_d;
            end
        end
    end

    // stoppable outputs stop while halt is low
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_processor_clock_enable <= 3'h7;
        end else begin
            o_processor_clock_enable <= ~(halt_select_q & {3{~halt_n_sync}});
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_ref_enable               <= cgor_pkg::REF_ENABLE_RST;
            o_ref_edge_rate            <= cgor_pkg::REF_EDGE_RATE_RST;
            o_processor_pll_multiplier <= {cgor_pkg::PROC_MULT_MSB_RST,
                                           cgor_pkg::PROC_MULT_LOW_FS0};
            o_panel_pll_multiplier     <=
                {cgor_pkg::RESERVED_C_VALUE[cgor_pkg::PANEL_MSB_BIT],
                 cgor_pkg::PANEL_MULT_VALUE};
            o_ready                    <= 1'h0;
        end else begin
            o_ref_enable               <= ref_enable_q;
            o_ref_edge_rate            <= ref_edge_rate_q;
            o_processor_pll_multiplier <= {processor_pll_multiplier_msb,
                                           processor_pll_multiplier_low_bits};
            o_panel_pll_multiplier     <=
                {cgor_pkg::RESERVED_C_VALUE[cgor_pkg::PANEL_MSB_BIT],
                 panel_pll_multiplier_bits};
            o_ready                    <= (state_q == cgor_pkg::CGOR_RUN);
        end
    end

endmodule

// ---- dv/cgor_regs_sva.sv ----
// port assertions for the configuration register bank
`timescale 1ns/1ps
module cgor_regs_chk (
    // clock and reset
    input wire logic       i_clk,
    input wire logic       i_reset,
    // byte register port
    input wire logic       i_wr_en,
    input wire logic       i_rd_en,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic [7:0] o_rdata,
    input wire logic       o_rdata_valid,
    input wire logic       o_ready,
    // pins and controls
    input wire logic       i_freq_select_b,
    input wire logic       i_freq_select_c,
    input wire logic [2:0] i_clock_request_n,
    input wire logic       i_processor_clock_halt_n,
    input wire logic       o_ref_enable,
    input wire logic [1:0] o_ref_edge_rate,
    input wire logic [2:0] o_processor_clock_enable,
    input wire logic [8:0] o_processor_pll_multiplier,
    input wire logic [8:0] o_panel_pll_multiplier
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    a_read_answer: assert property (i_rd_en |=> o_rdata_valid)
        else $error("read got no valid pulse");
    a_valid_cause: assert property (o_rdata_valid |-> $past(i_rd_en))
        else $error("valid pulse without a read");
    a_rdata_holds: assert property
        (!$past(i_rd_en) && !$past(i_reset) |-> $stable(o_rdata))
        else $error("read data moved without a read");
    a_ref_enable_wr: assert property (i_wr_en && o_ready &&
        i_addr == 8'h03 |-> ##2 o_ref_enable == $past(i_wdata[5], 2))
        else $error("reference enable not written");
    a_edge_rate_wr: assert property (i_wr_en && o_ready &&
        i_addr == 8'h03 |-> ##2 o_ref_edge_rate == $past(i_wdata[4:3], 2))
        else $error("edge rate not written");
    a_mult_msb_wr: assert property (i_wr_en && o_ready && i_addr == 8'h04
        |-> ##2 o_processor_pll_multiplier[8] == $past(i_wdata[0], 2))
        else $error("multiplier msb not written");
    a_mult_low_wr: assert property (i_wr_en && o_ready && i_addr == 8'h05
        |-> ##2 o_processor_pll_multiplier[7:0] == $past(i_wdata, 2))
        else $error("multiplier low byte not written");
    a_free_running: assert property
        (i_processor_clock_halt_n [*3] |=> o_processor_clock_enable == 3'h7)
        else $error("output stopped without halt");
    a_ready_holds: assert property (o_ready |=> o_ready)
        else $error("ready dropped");
    a_panel_fixed: assert property (o_ready |->
        o_panel_pll_multiplier == {1'b0, cgor_pkg::PANEL_MULT_VALUE})
        else $error("panel multiplier changed");
endmodule

bind cgor_regs cgor_regs_chk u_chk (
    .i_clk(i_clk), .i_reset(i_reset), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
    .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata),
    .o_rdata_valid(o_rdata_valid), .o_ready(o_ready),
    .i_freq_select_b(i_freq_select_b), .i_freq_select_c(i_freq_select_c),
    .i_clock_request_n(i_clock_request_n),
    .i_processor_clock_halt_n(i_processor_clock_halt_n),
    .o_ref_enable(o_ref_enable), .o_ref_edge_rate(o_ref_edge_rate),
    .o_processor_clock_enable(o_processor_clock_enable),
    .o_processor_pll_multiplier(o_processor_pll_multiplier),
    .o_panel_pll_multiplier(o_panel_pll_multiplier)
);

// ---- dv/cgor_host.sv ----
// host model issuing byte accesses to the register bank
`timescale 1ns/1ps
module cgor_host (
    // clock
    input  wire logic       i_clk,
    // read answer
    input  wire logic [7:0] i_rdata,
    input  wire logic       i_rdata_valid,
    // byte access request
    output logic            o_wr_en,
    output logic            o_rd_en,
    output logic      [7:0] o_addr,
    output logic      [7:0] o_wdata
);
    // idle request at start
    initial begin
        o_wr_en = 1'b0;
        o_rd_en = 1'b0;
        o_addr  = 8'h00;
        o_wdata = 8'h00;
    end

    // one byte write, lines scrambled once released
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        if (a == 8'h03 && d[4:3] == 2'h3) d[4:3] = 2'h2;
        @(posedge i_clk);
        o_wr_en <= 1'b1;
        o_addr  <= a;
        o_wdata <= d;
        @(posedge i_clk);
        o_wr_en <= 1'b0;
        o_addr  <= ~a;
        o_wdata <= ~d;
    endtask

    // one byte read, answer taken once settled
    task automatic rd(input logic [7:0] a, output logic [7:0] d,
                      output logic v);
        @(posedge i_clk);
        o_rd_en <= 1'b1;
        o_addr  <= a;
        @(posedge i_clk);
        o_rd_en <= 1'b0;
        o_addr  <= ~a;
        #1;
        d = i_rdata;
        v = i_rdata_valid;
    endtask
endmodule

// ---- dv/cgor_regs_tb.sv ----
// self-checking bench for the configuration register bank
`timescale 1ns/1ps
module cgor_regs_tb;
    logic       i_clk = 1'b0;
    logic       i_reset = 1'b1;
    logic       i_freq_select_b = 1'b1;
    logic       i_freq_select_c = 1'b0;
    logic [2:0] i_clock_request_n = 3'h5;
    logic       i_processor_clock_halt_n = 1'b1;
    logic       wr_en, rd_en, rvalid, ready, ref_en;
    logic [7:0] addr, wdata, rdata;
    logic [1:0] edge_rate;
    logic [2:0] cpu_en;
    logic [8:0] pmult, lmult;
    int         bad_count = 0;
    int         n_checks = 0;

    // 100 MHz clock
    always #5 i_clk = ~i_clk;

    cgor_regs DUT (
        .i_clk(i_clk), .i_reset(i_reset), .i_wr_en(wr_en), .i_rd_en(rd_en),
        .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata),
        .o_rdata_valid(rvalid), .o_ready(ready),
        .i_freq_select_b(i_freq_select_b), .i_freq_select_c(i_freq_select_c),
        .i_clock_request_n(i_clock_request_n),
        .i_processor_clock_halt_n(i_processor_clock_halt_n),
        .o_ref_enable(ref_en), .o_ref_edge_rate(edge_rate),
        .o_processor_clock_enable(cpu_en),
        .o_processor_pll_multiplier(pmult), .o_panel_pll_multiplier(lmult));

    cgor_host u_host (.i_clk(i_clk), .i_rdata(rdata), .i_rdata_valid(rvalid),
        .o_wr_en(wr_en), .o_rd_en(rd_en), .o_addr(addr), .o_wdata(wdata));

    task automatic tally_and_finish;
        $display("TB: checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // read a byte, expect a valid pulse and the value
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic       v;
        u_host.rd(a, d, v);
        chk({8'h00, v}, 9'h001);
        chk({1'b0, d}, {1'b0, exp});
    endtask

    // reset with given strap levels, then wait for ready
    task automatic do_reset(input logic b, input logic c, input logic early);
        @(posedge i_clk);
        i_reset         <= 1'b1;
        i_freq_select_b <= b;
        i_freq_select_c <= c;
        repeat (10) @(posedge i_clk);
        i_reset <= 1'b0;
        if (early) u_host.wr(8'h04, 8'h01);
        for (int k = 0; k < 20; k++) begin
            @(posedge i_clk);
            #1;
            if (ready === 1'b1) break;
        end
        chk({8'h00, ready}, 9'h001);
    endtask

    task automatic t_defaults;
        chk({8'h00, ref_en}, 9'h001);
        chk({7'h00, edge_rate}, 9'h002);
        chk({6'h00, cpu_en}, 9'h007);
        chk(pmult, 9'h020);
        chk(lmult, 9'h064);
        rchk(8'h03, 8'h30);
        rchk(8'h04, 8'hfe);
        rchk(8'h05, 8'h20);
        rchk(8'h0a, 8'ha8);
        $display("TB: defaults done");
    endtask

    task automatic t_outctl;
        u_host.wr(8'h03, 8'hef);
        repeat (2) @(posedge i_clk);
        #1;
        chk({7'h00, edge_rate}, 9'h001);
        rchk(8'h03, 8'h2f);
        u_host.wr(8'h03, 8'h10);
        repeat (2) @(posedge i_clk);
        #1;
        chk({8'h00, ref_en}, 9'h000);
        chk({7'h00, edge_rate}, 9'h002);
        rchk(8'h03, 8'h10);
        $display("TB: output control done");
    endtask

    task automatic t_mult;
        u_host.wr(8'h04, 8'h01);
        u_host.wr(8'h05, 8'ha5);
        repeat (2) @(posedge i_clk);
        #1;
        chk(pmult, 9'h1a5);
        rchk(8'h04, 8'hff);
        rchk(8'h05, 8'ha5);
        $display("TB: multiplier done");
    endtask

    task automatic t_readonly;
        logic [7:0] ad [6] = '{8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h20};
        logic [7:0] ex [6] = '{8'hc3, 8'h00, 8'h00, 8'h64, 8'ha8, 8'h00};
        for (int i = 0; i < 6; i++) u_host.wr(ad[i], 8'h5a);
        for (int i = 0; i < 6; i++) rchk(ad[i], ex[i]);
        chk(lmult, 9'h064);
        u_host.wr(8'h04, 8'h00);
        rchk(8'h04, 8'hfe);
        $display("TB: read-only done");
    endtask

    task automatic t_halt_live;
        u_host.wr(8'h03, 8'h34);
        @(posedge i_clk);
        i_processor_clock_halt_n <= 1'b0;
        i_clock_request_n        <= 3'h2;
        repeat (4) @(posedge i_clk);
        #1;
        chk({6'h00, cpu_en}, 9'h006);
        rchk(8'h0a, 8'h90);
        @(posedge i_clk);
        i_processor_clock_halt_n <= 1'b1;
        i_clock_request_n        <= 3'h5;
        repeat (4) @(posedge i_clk);
        #1;
        chk({6'h00, cpu_en}, 9'h007);
        $display("TB: halt and live pins done");
    endtask

    task automatic t_restrap;
        do_reset(1'b0, 1'b1, 1'b1);
        rchk(8'h05, 8'h30);
        rchk(8'h04, 8'hfe);
        rchk(8'h03, 8'h30);
        rchk(8'h0a, 8'h68);
        $display("TB: restrap done");
    endtask

    // main sequence
    initial begin
        do_reset(1'b1, 1'b0, 1'b0);
        t_defaults();
        t_outctl();
        t_mult();
        t_readonly();
        t_halt_live();
        t_restrap();
        tally_and_finish();
    end

    // watchdog against a hang
    initial begin
        repeat (3000) @(posedge i_clk);
        bad_count++;
        $display("[ERR] %0t watchdog expired", $time);
        tally_and_finish();
    end
endmodule
